// ==== rtl/psir_regs.sv ====
// Status and identifier management registers with their serial management slave.
// Assumes status inputs come from logic on mclk_i; MDC and MDIO arrive from pins.

`timescale 1ns/10ps

module psir_regs #(
    parameter logic [4:0]  PHY_ADDR  = 5'h00,
    parameter logic [23:0] VENDOR_ID = 24'h123456,   // Arbitrary value
    parameter logic [5:0]  MODEL_NUM = 6'h05,        // Arbitrary value
    parameter logic [3:0]  REVISION  = 4'h1          // Arbitrary value
) (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic mdc_i,
    input  wire logic mdio_i,
    output logic      mdio_o,
    output logic      mdio_oe_o,
    input  wire logic negotiation_done_i,
    input  wire logic remote_fault_i,
    input  wire logic link_up_i,
    input  wire logic jabber_i
);
    import psir_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers and MDC rising edge
    // ------------------------------------------------------------
    logic [1:0]  mdc_sync_reg;
    logic [1:0]  mdio_sync_reg;
    logic        mdc_prev_reg;
    logic        mdc_rise;
    logic        bit_in;

    // MDC resets low, its idle level, so no false edge follows reset
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mdc_sync_reg <= 2'h0;
        end else begin
            mdc_sync_reg <= {mdc_sync_reg[0], mdc_i};
        end
    end

    // MDIO resets high, the level of its pull-up
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mdio_sync_reg <= 2'h3;
        end else begin
            mdio_sync_reg <= {mdio_sync_reg[0], mdio_i};
        end
    end

    // Edge flop reads only the second synchroniser stage
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mdc_prev_reg <= 1'b0;
        end else begin
            mdc_prev_reg <= mdc_sync_reg[1];
        end
    end

    assign mdc_rise = mdc_sync_reg[1] & ~mdc_prev_reg;
    assign bit_in   = mdio_sync_reg[1];

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    logic        rd_clear;
    logic        remote_fault_reg;
    logic        jabber_reg;
    logic        link_latch_reg;

    // Set wins over the read clear, so an event in the clearing cycle survives
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            remote_fault_reg <= 1'b0;
        end else begin
            remote_fault_reg <= remote_fault_i | (remote_fault_reg & ~rd_clear);
        end
    end

    // Jabber is sticky in the same way
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            jabber_reg <= 1'b0;
        end else begin
            jabber_reg <= jabber_i | (jabber_reg & ~rd_clear);
        end
    end

    // Latch low on loss; a read reloads with the live link, so a loss is seen once
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            link_latch_reg <= 1'b0;
        end else if (rd_clear) begin
            link_latch_reg <= link_up_i;
        end else begin
            link_latch_reg <= link_latch_reg & link_up_i;
        end
    end

    // ------------------------------------------------------------
    // Register read words
    // ------------------------------------------------------------
    logic [15:0] status_word;
    logic [31:0] ident_word;

    always_comb begin
        // Constant abilities, reserved bits zero
        status_word = STATUS_RESET_VALUE;
        status_word[BIT_NEGOTIATION_DONE] = negotiation_done_i;
        status_word[BIT_REMOTE_FAULT]     = remote_fault_reg;
        status_word[BIT_LINK_LATCHED_LOW] = link_latch_reg;
        status_word[BIT_JABBER_FLAG]      = jabber_reg;
    end

    // Vendor id bit 1 is its MSB; bits 1 and 2 are dropped
    assign ident_word = {VENDOR_ID[21:0], MODEL_NUM, REVISION};

    // ------------------------------------------------------------
    // Serial management frame engine
    // ------------------------------------------------------------
    // Bits are taken three mclk after each MDC rise, so MDC high and low must
    // each last several mclk periods. A frame is start 01, op, five PHY and five
    // register address bits, two turnaround bits and sixteen data bits. No
    // preamble is required: idle waits for the start bit. A cut frame is only
    // left at the end of its count, so the station should finish every frame.
    // Reads answer only at this PHY address; writes are counted and dropped.
    psir_state_t state_reg;
    logic [4:0]  bit_cnt_reg;
    logic [1:0]  op_reg;
    logic [8:0]  addr_sh_reg;
    logic        respond_reg;
    logic [15:0] shift_reg;
    logic        mdio_reg;
    logic        mdio_oe_reg;
    logic [9:0]  addr_full;

    assign addr_full = {addr_sh_reg, bit_in};

    // Frame sequencer; idle waits for the start pattern, so preamble is optional
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 5'h00;
        end else if (mdc_rise) begin
            case (state_reg)
                ST_IDLE: begin
                    if (!bit_in) begin
                        state_reg <= ST_START;
                    end
                end
                ST_START: begin
                    state_reg   <= bit_in ? ST_OP : ST_IDLE;
                    bit_cnt_reg <= 5'h00;
                end
                ST_OP: begin
                    if (bit_cnt_reg == OP_BITS_LAST) begin
                        state_reg   <= ST_ADDR;
                        bit_cnt_reg <= 5'h00;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                ST_ADDR: begin
                    if (bit_cnt_reg == ADDR_BITS_LAST) begin
                        state_reg   <= ST_TURN;
                        bit_cnt_reg <= 5'h00;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                ST_TURN: begin
                    if (bit_cnt_reg == OP_BITS_LAST) begin
                        state_reg   <= ST_DATA;
                        bit_cnt_reg <= 5'h00;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                ST_DATA: begin
                    // Write data is counted and dropped: nothing here is writable
                    if (bit_cnt_reg == DATA_BITS_LAST) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Operation code, shifted in during the two op bits
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            op_reg <= 2'h0;
        end else if (mdc_rise && state_reg == ST_OP) begin
            op_reg <= {op_reg[0], bit_in};
        end
    end

    // PHY and register address, shifted in MSB first
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_sh_reg <= 9'h000;
        end else if (mdc_rise && state_reg == ST_ADDR) begin
            addr_sh_reg <= addr_full[8:0];
        end
    end

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic        addr_done;
    logic        read_frame;
    logic        read_hit;
    logic [15:0] read_word;
    logic        shift_step;

    // Last address bit is on the line at this MDC rise
    assign addr_done  = mdc_rise && state_reg == ST_ADDR && bit_cnt_reg == ADDR_BITS_LAST;
    assign read_frame = op_reg == OP_READ && addr_full[9:5] == PHY_ADDR;

    // Shift once bit 15 has been handed to the pin driver
    assign shift_step = mdc_rise && (state_reg == ST_DATA ||
                        (state_reg == ST_TURN && bit_cnt_reg == OP_BITS_LAST));

    // Other PHYs and unmapped registers leave the line to the pull-up
    always_comb begin
        read_hit  = 1'b0;
        read_word = 16'hFFFF;
        if (read_frame) begin
            case (addr_full[4:0])
                REG_BASIC_LINK_STATUS: begin
                    read_hit  = 1'b1;
                    read_word = status_word;
                end
                REG_IDENTIFIER_HIGH: begin
                    read_hit  = 1'b1;
                    read_word = ident_word[31:16];
                end
                REG_IDENTIFIER_LOW: begin
                    read_hit  = 1'b1;
                    read_word = ident_word[15:0];
                end
                default: begin
                    read_hit  = 1'b0;
                    read_word = 16'hFFFF;
                end
            endcase
        end
    end

    // Clear in the snapshot cycle itself, so no event can slip between snapshot and clear
    assign rd_clear = addr_done && read_frame &&
                      addr_full[4:0] == REG_BASIC_LINK_STATUS;

    // ------------------------------------------------------------
    // Read shift register
    // ------------------------------------------------------------
    // Snapshot of the addressed register at the last address bit
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            respond_reg <= 1'b0;
            shift_reg   <= 16'h0000;
        end else if (addr_done) begin
            respond_reg <= read_hit;
            shift_reg   <= read_word;
        end else if (shift_step) begin
            shift_reg <= {shift_reg[14:0], 1'b0};
        end
    end

    // Pin driver: zero in the second turnaround bit, then sixteen data bits
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mdio_reg    <= 1'b1;
            mdio_oe_reg <= 1'b0;
        end else if (mdc_rise && respond_reg) begin
            if (state_reg == ST_TURN && bit_cnt_reg == 5'h00) begin
                mdio_reg    <= 1'b0;
                mdio_oe_reg <= 1'b1;
            end else if (state_reg == ST_TURN) begin
                mdio_reg <= shift_reg[15];
            end else if (state_reg == ST_DATA && bit_cnt_reg != DATA_BITS_LAST) begin
                mdio_reg <= shift_reg[15];
            end else begin
                mdio_reg    <= 1'b1;
                mdio_oe_reg <= 1'b0;
            end
        end
    end

    assign mdio_o    = mdio_reg;
    assign mdio_oe_o = mdio_oe_reg;

endmodule

// ==== rtl/psir_pkg.sv ====
// Constants, register map and frame encodings for the status and identifier bank.
// Assumes the bank sits behind a serial management port clocked by the station's MDC.
//
// Operation
// - Status bits 14 to 11 always read one, for the four 10 and 100 Mb/s duplex abilities.
// - Status bit 8 always reads one, because gigabit extended status lives in register 15.
// - Status bit 6 reads one and frames without a preamble are accepted.
// - Status bit 5 reads one once negotiation has finished and zero before that.
// - Status bit 4 is set by a remote fault and cleared by a management read of the register.
// - Status bit 3 always reads one, since the device can negotiate.
// - Status bit 2 latches low on link loss until read, so the station reads twice for link up.
// - Status bit 1 is set by jabber and cleared by a management read of the register.
// - Status bit 0 always reads one, since the extended register set exists.
// - The two identifier registers form one 32-bit vendor, model and revision identifier.
// - The high identifier register holds vendor identifier bits 3 to 18 in bits 15 to 0.
// - The low one holds vendor bits 19 to 24, then the model in 9 to 4 and revision in 3 to 0.

package psir_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0]  REG_BASIC_LINK_STATUS = 5'h01;
    localparam logic [4:0]  REG_IDENTIFIER_HIGH   = 5'h02;
    localparam logic [4:0]  REG_IDENTIFIER_LOW    = 5'h03;

    // ------------------------------------------------------------
    // Status word layout
    // ------------------------------------------------------------
    localparam logic [15:0] STATUS_RESET_VALUE    = 16'h7949;
    localparam int          BIT_NEGOTIATION_DONE  = 5;
    localparam int          BIT_REMOTE_FAULT      = 4;
    localparam int          BIT_LINK_LATCHED_LOW  = 2;
    localparam int          BIT_JABBER_FLAG       = 1;

    // ------------------------------------------------------------
    // Management frame encodings
    // ------------------------------------------------------------
    localparam logic [1:0]  OP_READ               = 2'h2;
    localparam logic [1:0]  OP_WRITE              = 2'h1;
    localparam logic [4:0]  OP_BITS_LAST          = 5'h01;
    localparam logic [4:0]  ADDR_BITS_LAST        = 5'h09;
    localparam logic [4:0]  DATA_BITS_LAST        = 5'h0F;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_START = 3'h1,
        ST_OP    = 3'h3,
        ST_ADDR  = 3'h2,
        ST_TURN  = 3'h6,
        ST_DATA  = 3'h7
    } psir_state_t;

endpackage

// ==== verif/psir_regs_chk.sv ====
// Port checker for the status and identifier bank.
// Assumes MDC and MDIO change away from rising mclk_i edges.
`timescale 1ns/10ps
module psir_regs_chk
    import psir_pkg::*;
#(
    parameter logic [4:0]  PHY_ADDR  = 5'h00,
    parameter logic [23:0] VENDOR_ID = 24'h000000,
    parameter logic [5:0]  MODEL_NUM = 6'h00,
    parameter logic [3:0]  REVISION  = 4'h0
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    input wire logic mdio_o,
    input wire logic mdio_oe_o,
    input wire logic negotiation_done_i,
    input wire logic remote_fault_i,
    input wire logic link_up_i,
    input wire logic jabber_i
);
    logic        mdc_reg;
    logic [14:0] hdr_reg;
    logic [4:0]  addr_reg;
    logic [4:0]  cnt_reg;
    logic [4:0]  bit_n;
    logic        rise;
    logic        chk;
    logic        st;
    logic [15:0] id_hi;
    logic [15:0] id_lo;
    // ----
    // Pin-side frame tracking: bit_n is the data bit shown at this MDC rise
    // ----
    assign rise  = mdc_i & ~mdc_reg;
    assign chk   = rise & mdio_oe_o & (cnt_reg != 5'h00) & (cnt_reg <= 5'h10);
    assign st    = chk & (addr_reg == REG_BASIC_LINK_STATUS);
    assign bit_n = 5'h10 - cnt_reg;
    assign id_hi = VENDOR_ID[21:6];
    assign id_lo = {VENDOR_ID[5:0], MODEL_NUM, REVISION};
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mdc_reg  <= 1'b0;
            hdr_reg  <= 15'h0000;
            addr_reg <= 5'h00;
            cnt_reg  <= 5'h00;
        end else begin
            mdc_reg <= mdc_i;
            if (rise) hdr_reg <= {hdr_reg[13:0], mdio_i};
            if (!mdio_oe_o) addr_reg <= hdr_reg[5:1];
            if (!mdio_oe_o) cnt_reg <= 5'h00;
            else if (rise) cnt_reg <= cnt_reg + 5'h01;
        end
    end
    property p_read_drive;
        $rose(mdio_oe_o) |-> !mdio_o && hdr_reg[14:11] == {2'b01, OP_READ}
            && hdr_reg[10:6] == PHY_ADDR && hdr_reg[5:1] inside {[5'h01:5'h03]};
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("drive without read");
    property p_abilities;
        st && bit_n inside {[5'h0B:5'h0E]} |-> mdio_o;
    endproperty
    a_abilities: assert property (p_abilities) else $error("ability bit low");
    property p_gig;
        st && bit_n == 5'h08 |-> mdio_o;
    endproperty
    a_gig: assert property (p_gig) else $error("gigabit bit low");
    property p_no_pre;
        st && bit_n == 5'h06 |-> mdio_o;
    endproperty
    a_no_pre: assert property (p_no_pre) else $error("preamble bit low");
    property p_neg_able;
        st && bit_n == 5'h03 |-> mdio_o;
    endproperty
    a_neg_able: assert property (p_neg_able) else $error("negotiation bit low");
    property p_ext_set;
        st && bit_n == 5'h00 |-> mdio_o;
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("extended bit low");
    property p_reserved;
        st && bit_n inside {5'h0F, 5'h0A, 5'h09, 5'h07} |-> !mdio_o;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit high");
    property p_id_hi;
        chk && addr_reg == REG_IDENTIFIER_HIGH |-> mdio_o == id_hi[bit_n[3:0]];
    endproperty
    a_id_hi: assert property (p_id_hi) else $error("high id bit wrong");
    property p_id_lo;
        chk && addr_reg == REG_IDENTIFIER_LOW |-> mdio_o == id_lo[bit_n[3:0]];
    endproperty
    a_id_lo: assert property (p_id_lo) else $error("low id bit wrong");
    property p_word_end;
        chk && cnt_reg == 5'h10 |=> ##[0:12] !mdio_oe_o;
    endproperty
    a_word_end: assert property (p_word_end) else $error("drive too long");
    c_status: cover property (st && bit_n == 5'h00);
    c_id_hi: cover property (chk && addr_reg == REG_IDENTIFIER_HIGH);
    c_id_lo: cover property (chk && addr_reg == REG_IDENTIFIER_LOW);
endmodule
bind psir_regs psir_regs_chk #(.PHY_ADDR(PHY_ADDR), .VENDOR_ID(VENDOR_ID),
    .MODEL_NUM(MODEL_NUM), .REVISION(REVISION)) i_chk (.mclk_i(mclk_i), .rst_i(rst_i),
    .mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
    .negotiation_done_i(negotiation_done_i), .remote_fault_i(remote_fault_i),
    .link_up_i(link_up_i), .jabber_i(jabber_i));

// ==== verif/psir_mgmt_model.sv ====
// Station management controller model: frames MDC and MDIO.
// Assumes the line has a pull-up while nobody drives it.
`timescale 1ns/10ps
module psir_mgmt_model
    import psir_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic dut_mdio_i,
    input  wire logic dut_oe_i,
    output logic      mdc_o,
    output logic      mdio_o
);
    logic drv_en = 1'b0;
    logic drv_val = 1'b1;
    assign mdio_o = drv_en ? drv_val : (dut_oe_i ? dut_mdio_i : 1'b1);
    initial mdc_o = 1'b0;
    task automatic clk_bit(input logic v, input logic en, output logic seen);
        drv_en  = en;
        drv_val = v;
        repeat (8) @(negedge mclk_i);
        seen  = mdio_o;
        mdc_o = 1'b1;
        repeat (8) @(negedge mclk_i);
        mdc_o = 1'b0;
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, input logic pre, output logic [15:0] rd);
        logic [13:0] hdr;
        logic        s;
        logic        wr;
        int          i;
        hdr = {2'b01, op, phy, ra};
        wr  = (op == OP_WRITE);
        if (pre) for (i = 0; i < 32; i++) clk_bit(1'b1, 1'b1, s);
        for (i = 13; i >= 0; i--) clk_bit(hdr[i], 1'b1, s);
        clk_bit(1'b1, wr, s);
        clk_bit(1'b0, wr, s);
        for (i = 15; i >= 0; i--) begin
            clk_bit(wd[i], wr, s);
            rd[i] = s;
        end
        drv_en = 1'b0;
        @(negedge mclk_i);
    endtask
endmodule

// ==== verif/psir_regs_test.sv ====
// Self-checking bench for the status and identifier bank.
// Frames go through the management model; event inputs change at mclk fall.
`timescale 1ns/10ps
module psir_regs_test;
    import psir_pkg::*;
    localparam logic [4:0]  PHY = 5'h0B;
    localparam logic [23:0] VID = 24'h5A3C96; // Arbitrary value
    localparam logic [5:0]  MOD = 6'h2D;      // Arbitrary value
    localparam logic [3:0]  REV = 4'h6;       // Arbitrary value
    localparam logic [15:0] ST  = 16'h7949;
    logic        mclk_i, rst_i, mdc, mdio, dut_mdio, dut_oe, neg, rf, link, jab;
    logic [15:0] rd;
    int          bad_count, checks, k;
    psir_regs #(.PHY_ADDR(PHY), .VENDOR_ID(VID), .MODEL_NUM(MOD), .REVISION(REV)) i_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(dut_mdio),
        .mdio_oe_o(dut_oe), .negotiation_done_i(neg), .remote_fault_i(rf),
        .link_up_i(link), .jabber_i(jab));
    psir_mgmt_model i_mgmt (.mclk_i(mclk_i), .dut_mdio_i(dut_mdio), .dut_oe_i(dut_oe),
        .mdc_o(mdc), .mdio_o(mdio));
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    task automatic rd_chk(input string what, input logic [4:0] phy, input logic [4:0] ra,
                          input logic pre, input logic [15:0] exp);
        i_mgmt.frame(OP_READ, phy, ra, 16'h0000, pre, rd);
        checks++;
        if (rd !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, rd);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge mclk_i);
        bad_count++;
        give_verdict();
    end
    initial begin
        {rst_i, neg, rf, link, jab, bad_count, checks} = {5'b10010, 64'h0};
        repeat (3) @(negedge mclk_i);
        rst_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        rd_chk("stat", PHY, REG_BASIC_LINK_STATUS, 1'b0, ST);
        rd_chk("status", PHY, REG_BASIC_LINK_STATUS, 1'b0, ST | 16'h0004);
        rd_chk("id high", PHY, REG_IDENTIFIER_HIGH, 1'b1, VID[21:6]);
        rd_chk("id low", PHY, REG_IDENTIFIER_LOW, 1'b1, {VID[5:0], MOD, REV});
        $display("test reset and identity done");
        i_mgmt.frame(OP_WRITE, PHY, REG_BASIC_LINK_STATUS, 16'h0000, 1'b0, rd);
        i_mgmt.frame(OP_WRITE, PHY, REG_IDENTIFIER_HIGH, 16'hFFFF, 1'b0, rd);
        rd_chk("status", PHY, REG_BASIC_LINK_STATUS, 1'b0, ST | 16'h0004);
        rd_chk("id high", PHY, REG_IDENTIFIER_HIGH, 1'b0, VID[21:6]);
        $display("test writes done");
        neg = 1'b1;
        rd_chk("status", PHY, REG_BASIC_LINK_STATUS, 1'b0, ST | 16'h0024);
        for (k = 0; k < 2; k++) begin
            rf  = (k == 0);
            jab = (k == 1);
            @(negedge mclk_i);
            {rf, jab} = 2'b00;
            rd_chk("flag", PHY, 5'h01, 1'b0, ST | (k == 0 ? 16'h0034 : 16'h0026));
            rd_chk("flag", PHY, 5'h01, 1'b0, ST | 16'h0024);
        end
        $display("test flags done");
        link = 1'b0;
        @(negedge mclk_i);
        link = 1'b1;
        rd_chk("link", PHY, REG_BASIC_LINK_STATUS, 1'b0, ST | 16'h0020);
        rd_chk("link", PHY, REG_BASIC_LINK_STATUS, 1'b0, ST | 16'h0024);
        rd_chk("other phy", PHY ^ 5'h01, 5'h01, 1'b0, 16'hFFFF);
        rd_chk("unmapped", PHY, 5'h04, 1'b0, 16'hFFFF);
        $display("test link and refusals done");
        give_verdict();
    end
endmodule
